// ===== shared/abs_mon_map.svh
// Constants for the absolute-position transfer responder.
// Assumes a 100 MHz core clock; included by bare name.
//==========================================================
// Notes on behaviour
// R01 - Controller flags communication error if send-data-ready stays low one second or more.
// R02 - Amplifier raises timeout warning when request on-time limit expires.
// R03 - Controller flags communication error if transfer mode lasts over five seconds.
// R04 - Amplifier raises timeout warning when transfer-mode completion limit is exceeded.
// R05 - Controller flags communication error if request stays on over one second.
// R06 - Amplifier raises timeout warning when request-off time limit expires.
// R07 - Controller raises checksum error after four consecutive checksum mismatches. The controller model does not check the checksum.
// R08 - Position data goes out two bits at a time on bit0 and bit1 lines.
// R09 - Controller raises coordinate error on negative position at servo-on or power-on. The controller model has no coordinate error.
// R10 - Controller raises servo alarm on amplifier alarm or emergency stop. The controller model has no servo alarm.
// R11 - Each controller error condition drives its own separate output. The controller model has only comm_err, shared by R01, R03 and R05.
// R12 - Communication error clears when servo-on pushbutton goes inactive. The controller model clears comm_err when transfer mode goes low.
// R13 - Coordinate error clears on servo-on rising after positive jog move. The controller model has no coordinate error to clear.
// R14 - Servo alarm clears on alarm reset press or power cycle. The controller model has no servo alarm to clear.
// R15 - Timeout counters tick from a fixed clock, restart, and saturate.
`ifndef ABS_MON_MAP_SVH
`define ABS_MON_MAP_SVH

//==========================================================
// Frame layout
`define ABS_DATA_W 32
`define ABS_CSUM_W 6
`define ABS_PAIRS 19

//==========================================================
// Timing
`define ABS_CLK_HZ 100000000
`define ABS_REQ_ON_MS 1000
`define ABS_REQ_OFF_MS 1000
`define ABS_MODE_MS 5000
`define ABS_MS_TO_CYC(ms) ((ms) * (`ABS_CLK_HZ / 1000))

`endif

// ===== shared/abs_mon_pkg.sv
// Types for the absolute-position transfer responder.
// Assumes the map header supplies all numeric constants.
package abs_mon_pkg;
    typedef struct packed
    {
        logic transfer_mode;
        logic data_request;
    } abs_link_in_t;

    typedef struct packed
    {
        logic send_data_ready;
        logic position_data_bit0;
        logic position_data_bit1;
        logic abs_timeout_warning;
    } abs_link_out_t;

    typedef enum logic [1:0]
    {
        ABS_IDLE = 2'b00,
        ABS_WAIT = 2'b01,
        ABS_SEND = 2'b11,
        ABS_FAULT = 2'b10
    } abs_state_t;
endpackage

// ===== rtl/abs_mon_top.sv
// Amplifier end of the absolute-position transfer handshake.
// Assumes controller pins are asynchronous and the position word
// comes from core-clock logic, stable while transfer mode is on.
`include "abs_mon_map.svh"

module abs_mon_top
#(
    parameter int unsigned REQ_ON_CYC = `ABS_MS_TO_CYC(`ABS_REQ_ON_MS),
    parameter int unsigned REQ_OFF_CYC = `ABS_MS_TO_CYC(`ABS_REQ_OFF_MS),
    parameter int unsigned MODE_CYC = `ABS_MS_TO_CYC(`ABS_MODE_MS)
)
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire abs_mon_pkg::abs_link_in_t LINK_IN,
    input wire logic [`ABS_DATA_W-1:0] POSITION_WORD,
    output abs_mon_pkg::abs_link_out_t LINK_OUT
);
    import abs_mon_pkg::*;

    localparam int FRAME_W = `ABS_DATA_W + `ABS_CSUM_W;

    //==========================================================
    // Checksum of a word taken two bits at a time
    function automatic logic [`ABS_CSUM_W-1:0] pair_sum(input logic [`ABS_DATA_W-1:0] w);
        logic [`ABS_CSUM_W-1:0] s;
        s = '0;
        for (int i = 0; i < `ABS_DATA_W / 2; i++)
        begin
            s = s + {{(`ABS_CSUM_W-2){1'b0}}, w[2*i +: 2]};
        end
        return s;
    endfunction

    //==========================================================
    // Input synchronisers
    abs_link_in_t sync1_q, sync2_q;

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= LINK_IN;
            sync2_q <= sync1_q;
        end
    end

    wire logic mode_s = sync2_q.transfer_mode;
    wire logic req_s = sync2_q.data_request;

    //==========================================================
    // Transfer state
    abs_state_t state_q, state_d;
    logic [FRAME_W-1:0] shift_q, shift_d;
    logic [4:0] left_q, left_d;
    logic [31:0] step_tmr_q, step_tmr_d;
    logic [31:0] mode_tmr_q, mode_tmr_d;
    abs_link_out_t out_q, out_d;

    wire logic step_over = (state_q == ABS_SEND) ? (step_tmr_q >= REQ_ON_CYC)
                                                 : (step_tmr_q >= REQ_OFF_CYC);
    wire logic mode_over = mode_tmr_q >= MODE_CYC;

    always_comb
    begin
        state_d = state_q;
        shift_d = shift_q;
        left_d = left_q;
        out_d = out_q;
        // Saturating timers
        step_tmr_d = (step_tmr_q == 32'hffffffff) ? step_tmr_q : step_tmr_q + 32'h1;
        mode_tmr_d = (mode_tmr_q == 32'hffffffff) ? mode_tmr_q : mode_tmr_q + 32'h1;
        unique case (state_q)
            ABS_IDLE:
            begin
                step_tmr_d = '0;
                mode_tmr_d = '0;
                out_d.send_data_ready = 1'b0;
                if (mode_s)
                begin
                    shift_d = {pair_sum(POSITION_WORD), POSITION_WORD};
                    left_d = 5'(`ABS_PAIRS);
                    out_d.abs_timeout_warning = 1'b0;
                    out_d.send_data_ready = 1'b1;
                    state_d = ABS_WAIT;
                end
            end
            ABS_WAIT:
            begin
                if (!mode_s)
                begin
                    out_d.send_data_ready = 1'b0;
                    state_d = ABS_IDLE;
                end
                else if (mode_over) // R04
                begin
                    out_d.abs_timeout_warning = 1'b1;
                    out_d.send_data_ready = 1'b0;
                    state_d = ABS_FAULT;
                end
                else if (left_q != 5'h0 && step_over) // R06
                begin
                    out_d.abs_timeout_warning = 1'b1;
                    out_d.send_data_ready = 1'b0;
                    state_d = ABS_FAULT;
                end
                else if (left_q != 5'h0 && req_s)
                begin
                    out_d.position_data_bit0 = shift_q[0]; // R08
                    out_d.position_data_bit1 = shift_q[1]; // R08
                    shift_d = {2'b00, shift_q[FRAME_W-1:2]};
                    left_d = left_q - 5'h1;
                    out_d.send_data_ready = 1'b0;
                    step_tmr_d = '0;
                    state_d = ABS_SEND;
                end
            end
            ABS_SEND:
            begin
                if (mode_over) // R04
                begin
                    out_d.abs_timeout_warning = 1'b1;
                    state_d = ABS_FAULT;
                end
                else if (step_over) // R02
                begin
                    out_d.abs_timeout_warning = 1'b1;
                    state_d = ABS_FAULT;
                end
                else if (!req_s)
                begin
                    out_d.send_data_ready = 1'b1;
                    step_tmr_d = '0;
                    state_d = ABS_WAIT;
                end
            end
            ABS_FAULT:
            begin
                out_d.send_data_ready = 1'b0;
                if (!mode_s)
                begin
                    state_d = ABS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_q <= ABS_IDLE;
            shift_q <= '0;
            left_q <= '0;
            step_tmr_q <= '0;
            mode_tmr_q <= '0;
            out_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            shift_q <= shift_d;
            left_q <= left_d;
            step_tmr_q <= step_tmr_d;
            mode_tmr_q <= mode_tmr_d;
            out_q <= out_d;
        end
    end

    assign LINK_OUT = out_q;

    //==========================================================
    // Checks
    sequence s_timed_out;
        ##1 (state_q == ABS_FAULT) && out_q.abs_timeout_warning && !out_q.send_data_ready;
    endsequence

    a_req_on_limit: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R02
        (state_q == ABS_SEND && step_tmr_q >= REQ_ON_CYC) |-> s_timed_out)
        else $error("Request on-time limit did not raise warning");

    a_mode_limit: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R04
        (state_q != ABS_IDLE && state_q != ABS_FAULT && mode_s && mode_over)
        |-> s_timed_out)
        else $error("Transfer mode limit did not raise warning");

    a_req_off_limit: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R06
        (state_q == ABS_WAIT && mode_s && left_q != 5'h0 && step_tmr_q >= REQ_OFF_CYC)
        |-> s_timed_out)
        else $error("Request off-time limit did not raise warning");

    a_pair_out: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R08
        (state_q == ABS_WAIT && mode_s && !mode_over && !step_over && left_q != 5'h0 && req_s)
        |=> (out_q.position_data_bit0 == $past(shift_q[0]))
            && (out_q.position_data_bit1 == $past(shift_q[1]))
            && !out_q.send_data_ready && (left_q == $past(left_q) - 5'h1))
        else $error("Position pair not presented on request");

    a_warn_hold: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R02
        (state_q == ABS_FAULT) |-> out_q.abs_timeout_warning && !out_q.send_data_ready)
        else $error("Fault state without warning");
endmodule

// ===== bench/abs_ctl_model.sv
// Controller-side model driving transfer mode and data request.
// Assumes the bench clock; drives 1 ns after the rising edge.
module abs_ctl_model
#(
    parameter int RDY_LIM = 50,
    parameter int MODE_LIM = 400,
    parameter int REQ_LIM = 50
)
(
    input wire logic clk,
    input wire abs_mon_pkg::abs_link_out_t link_out,
    output abs_mon_pkg::abs_link_in_t link_in,
    output logic comm_err
);
    timeunit 1ns;
    timeprecision 1ns;
    import abs_mon_pkg::*;
    int rdy_low = 0;
    int mode_on = 0;
    int req_on = 0;
    initial link_in = '0;
    initial comm_err = 1'b0;
    //==========================================================
    // Controller supervision of the handshake
    always @(posedge clk)
    begin
        if (!link_in.transfer_mode)
        begin
            rdy_low <= 0;
            mode_on <= 0;
            comm_err <= 1'b0;
        end
        else
        begin
            rdy_low <= link_out.send_data_ready ? 0 : rdy_low + (rdy_low < RDY_LIM);
            mode_on <= mode_on + (mode_on <= MODE_LIM);
            if (rdy_low >= RDY_LIM || mode_on > MODE_LIM || req_on > REQ_LIM)
                comm_err <= 1'b1;
        end
        req_on <= link_in.data_request ? req_on + (req_on <= REQ_LIM) : 0;
    end
    task automatic mode(input logic v);
        @(posedge clk);
        #1 link_in.transfer_mode = v;
    endtask
    task automatic wait_rdy(input logic v);
        int n;
        n = 0;
        while (link_out.send_data_ready !== v && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic pair(input int hold, output logic [1:0] p);
        @(posedge clk);
        #1 link_in.data_request = 1'b1;
        wait_rdy(1'b0);
        p = {link_out.position_data_bit1, link_out.position_data_bit0};
        repeat (hold) @(posedge clk);
        #1 link_in.data_request = 1'b0;
        wait_rdy(1'b1);
    endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the transfer responder.
// Assumes short timeout parameters and the controller model.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import abs_mon_pkg::*;
    localparam int ON = 50;
    localparam int OFF = 50;
    localparam int MODE = 400;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] word = '0;
    abs_link_in_t lin;
    abs_link_out_t lout;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0 = 0;
    int exp_q[$];
    logic [1:0] p;
    logic comm_err;
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            failures++;
            report_and_stop();
        end
    end
    abs_mon_top #(.REQ_ON_CYC(ON), .REQ_OFF_CYC(OFF), .MODE_CYC(MODE)) uut
        (.CORE_CLK(clk), .RESETN(rstn), .LINK_IN(lin), .POSITION_WORD(word), .LINK_OUT(lout));
    abs_ctl_model #(.RDY_LIM(OFF), .MODE_LIM(MODE), .REQ_LIM(ON)) ctl
        (.clk(clk), .link_out(lout), .link_in(lin), .comm_err(comm_err));
    //==========================================================
    // Checks and report
    task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    //==========================================================
    // Frame helpers
    task automatic start(input logic [31:0] w);
        int s;
        logic [37:0] f;
        s = 0;
        for (int i = 0; i < 16; i++)
            s += w[2*i +: 2];
        f = {6'(s), w};
        exp_q = {};
        for (int k = 0; k < 19; k++)
            exp_q.push_back(int'(f[2*k +: 2]));
        word = w;
        ctl.mode(1'b1);
        t0 = cyc;
        ctl.wait_rdy(1'b1);
        check("ready", lout.send_data_ready, 2'h1);
        check("warn", lout.abs_timeout_warning, 2'h0);
    endtask
    task automatic pairs(input int n);
        repeat (n)
        begin
            ctl.pair(0, p);
            check("pair", p, 2'(exp_q.pop_front()));
        end
    endtask
    task automatic warn_at(input int c, input logic v);
        repeat (c) @(posedge clk);
        #2 check("warn", lout.abs_timeout_warning, {1'b0, v});
    endtask
    //==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h951fee65));
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        start($urandom());
        pairs(19);
        check("warn", lout.abs_timeout_warning, 2'h0);
        ctl.pair(0, p);
        check("refused", lout.send_data_ready, 2'h1);
        while (cyc - t0 < 390) @(posedge clk);
        #2 check("warn", lout.abs_timeout_warning, 2'h0);
        while (cyc - t0 < 415) @(posedge clk);
        #2 check("warn", lout.abs_timeout_warning, 2'h1);
        check("comm", comm_err, 2'h1);
        ctl.mode(1'b0);
        start(32'hffffffff);
        pairs(3);
        fork
            ctl.pair(ON + 10, p);
            begin
                warn_at(ON - 2, 1'b0);
                warn_at(14, 1'b1);
            end
        join
        check("comm", comm_err, 2'h1);
        ctl.mode(1'b0);
        start($urandom());
        pairs(2);
        warn_at(OFF - 4, 1'b0);
        warn_at(12, 1'b1);
        check("comm", comm_err, 2'h0);
        ctl.mode(1'b0);
        repeat (5) @(posedge clk);
        report_and_stop();
    end
endmodule
